// File: tccu_event_source.sv
// Far-side model: external capture pin and comparator two flag.
// Assumes the bench requests levels; the lines move just after a rising
// edge of pclk and hold until the next request.
`timescale 1ns/10ps

module tccu_event_source
(
    // Clock
    input  wire logic pclk,
    // Requested levels
    input  wire logic want_pin,
    input  wire logic want_cmp,
    // Event lines towards the unit
    output logic      capture_input_pin,
    output logic      comparator_two_flag
);
    // Levels follow the request one edge later; the unit is held in
    // reset over the first edges, so the unknown start level is harmless
    always @(posedge pclk)
    begin
        capture_input_pin   <= want_pin;
        comparator_two_flag <= want_cmp;
    end
endmodule

// File: tccu_pkg.sv
// Constants of the timer capture/compare unit: register indices, field
// positions, reset values and timing counts.
// Assumes a 20 MHz bus clock and APB register access, one word per index.
package tccu_pkg;

    // ****************************************************************
    // Register indices (byte address = 4 * index)
    // ****************************************************************
    localparam logic [5:0] IDX_TIMER_CONTROL      = 6'h12;
    localparam logic [5:0] IDX_TIMER_FLAGS        = 6'h13;
    localparam logic [5:0] IDX_CAPTURE_VALUE_HIGH = 6'h14;
    localparam logic [5:0] IDX_CAPTURE_VALUE_LOW  = 6'h15;
    localparam logic [5:0] IDX_COMPARE_VALUE_HIGH = 6'h16;
    localparam logic [5:0] IDX_COMPARE_VALUE_LOW  = 6'h17;
    localparam logic [5:0] IDX_COUNTER_HIGH_BYTE  = 6'h18;
    localparam logic [5:0] IDX_COUNTER_LOW_BYTE   = 6'h19;
    localparam logic [5:0] IDX_ANALOG_CONTROL     = 6'h1D;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTL_CAPTURE_IRQ_ENABLE  = 7;
    localparam int CTL_COMPARE_IRQ_ENABLE  = 6;
    localparam int CTL_OVERFLOW_IRQ_ENABLE = 5;
    localparam int CTL_CAPTURE_EDGE_SELECT = 1;
    localparam int CTL_COMPARE_OUT_LEVEL   = 0;
    localparam int FLG_CAPTURE             = 7;
    localparam int FLG_COMPARE             = 6;
    localparam int FLG_OVERFLOW            = 5;
    localparam int ANA_CAPTURE_SOURCE      = 0;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [15:0] COUNTER_RESET   = 16'hFFFC;
    localparam logic [15:0] COUNTER_ALL_ONE = 16'hFFFF;
    localparam logic [15:0] COUNTER_STEP    = 16'h0001;
    localparam logic [1:0]  PRESCALE_LAST   = 2'h3;  // Divide by four
    localparam logic [1:0]  PRESCALE_FIRST  = 2'h0;
    localparam logic [1:0]  PRESCALE_STEP   = 2'h1;

endpackage

// File: tccu_top.sv
// Timer capture/compare unit: 16-bit free-running counter with input
// capture and output compare, registers reached over APB.
// Assumes all inputs but the capture pin synchronous to pclk; comparator flag comes from an
// on-chip block, the capture pin from outside through a three-stage synchroniser.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps

module tccu_top
(
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Event sources
    input  wire logic        capture_input_pin,
    input  wire logic        comparator_two_flag,
    // Compare pin and port direction
    input  wire logic        compare_pin_is_output,
    output logic             compare_output_pin,
    output logic             compare_output_oe_n,
    // Interrupt request
    output logic             timer_irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0]  presc;
        logic [15:0] count;
        logic [15:0] cap;
        logic [15:0] cmpv;
        logic        capture_irq_enable;
        logic        compare_irq_enable;
        logic        overflow_irq_enable;
        logic        edge_sel;
        logic        compare_output_level;
        logic        src_sel;
        logic        capture_flag;
        logic        compare_flag;
        logic        overflow_flag;
        logic        arm_icf;
        logic        arm_ocf;
        logic        arm_tof;
        logic        cap_block;
        logic        cmp_inhibit;
        logic        s1;
        logic        s2;
        logic        s3;
        logic        cmp_q;
        logic [15:0] c1;
        logic [15:0] c2;
        logic        out_latch;
        logic        oe_n;
        logic        irq;
        logic        ready;
        logic [31:0] rdata;
        logic        slverr;
    } tccu_state_s;

    tccu_state_s st;
    tccu_state_s next_st;

    logic [5:0]  idx;
    logic        mapped;
    logic        acc_done;
    logic        acc_rd;
    logic        acc_wr;
    logic        tick;
    logic        cmp_hit;
    logic        pin_edge;
    logic        flag_edge;
    logic        cap_hit;
    logic [15:0] cap_value;
    logic [7:0]  rd_byte;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // Word index and completion of an access phase
    assign idx      = paddr[7:2];
    assign acc_done = psel && penable && st.ready;
    assign acc_rd   = acc_done && !pwrite;
    assign acc_wr   = acc_done && pwrite;

    // Map check: aligned word at one of the known indices
    always_comb
    begin
        mapped = 1'b0;
        if (paddr[1:0] == 2'b00)
        begin
            unique case (idx)
                tccu_pkg::IDX_TIMER_CONTROL,
                tccu_pkg::IDX_TIMER_FLAGS,
                tccu_pkg::IDX_CAPTURE_VALUE_HIGH,
                tccu_pkg::IDX_CAPTURE_VALUE_LOW,
                tccu_pkg::IDX_COMPARE_VALUE_HIGH,
                tccu_pkg::IDX_COMPARE_VALUE_LOW,
                tccu_pkg::IDX_COUNTER_HIGH_BYTE,
                tccu_pkg::IDX_COUNTER_LOW_BYTE,
                tccu_pkg::IDX_ANALOG_CONTROL: mapped = 1'b1;
                default:                      mapped = 1'b0;
            endcase
        end
    end

    // Read data of the addressed byte register
    always_comb
    begin
        rd_byte = 8'h00;
        unique case (idx)
            tccu_pkg::IDX_TIMER_CONTROL:
            begin
                rd_byte[tccu_pkg::CTL_CAPTURE_IRQ_ENABLE]  = st.capture_irq_enable;
                rd_byte[tccu_pkg::CTL_COMPARE_IRQ_ENABLE]  = st.compare_irq_enable;
                rd_byte[tccu_pkg::CTL_OVERFLOW_IRQ_ENABLE] = st.overflow_irq_enable;
                rd_byte[tccu_pkg::CTL_CAPTURE_EDGE_SELECT] = st.edge_sel;
                rd_byte[tccu_pkg::CTL_COMPARE_OUT_LEVEL]   = st.compare_output_level;
            end
            tccu_pkg::IDX_TIMER_FLAGS:
            begin
                rd_byte[tccu_pkg::FLG_CAPTURE]  = st.capture_flag;
                rd_byte[tccu_pkg::FLG_COMPARE]  = st.compare_flag;
                rd_byte[tccu_pkg::FLG_OVERFLOW] = st.overflow_flag;
            end
            tccu_pkg::IDX_CAPTURE_VALUE_HIGH: rd_byte = st.cap[15:8];
            tccu_pkg::IDX_CAPTURE_VALUE_LOW:  rd_byte = st.cap[7:0];
            tccu_pkg::IDX_COMPARE_VALUE_HIGH: rd_byte = st.cmpv[15:8];
            tccu_pkg::IDX_COMPARE_VALUE_LOW:  rd_byte = st.cmpv[7:0];
            tccu_pkg::IDX_COUNTER_HIGH_BYTE:  rd_byte = st.count[15:8];
            tccu_pkg::IDX_COUNTER_LOW_BYTE:   rd_byte = st.count[7:0];
            tccu_pkg::IDX_ANALOG_CONTROL:
                rd_byte[tccu_pkg::ANA_CAPTURE_SOURCE] = st.src_sel;
            default:                          rd_byte = 8'h00;
        endcase
    end

    // ****************************************************************
    // Event detection
    // ****************************************************************
    // Prescaler end, compare match and capture edges
    assign tick      = (st.presc == tccu_pkg::PRESCALE_LAST);
    assign cmp_hit   = (st.presc == tccu_pkg::PRESCALE_FIRST) &&
                       !st.cmp_inhibit &&
                       (st.count == st.cmpv);
    assign pin_edge  = st.edge_sel ? (st.s2 && !st.s3)
                                   : (!st.s2 && st.s3);
    assign flag_edge = st.edge_sel ? (comparator_two_flag && !st.cmp_q)
                                   : (!comparator_two_flag && st.cmp_q);
    assign cap_hit   = (st.src_sel ? flag_edge : pin_edge) &&
                       !st.cap_block;
    // Value one above the counter before the transition
    assign cap_value = st.src_sel ?
                       16'(st.count + tccu_pkg::COUNTER_STEP) :
                       16'(st.c2 + tccu_pkg::COUNTER_STEP);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_st = st;

        // Synchroniser, counter alignment and comparator history
        next_st.s1    = capture_input_pin;
        next_st.s2    = st.s1;
        next_st.s3    = st.s2;
        next_st.c1    = st.count;
        next_st.c2    = st.c1;
        next_st.cmp_q = comparator_two_flag;

        // Prescaler and counter
        next_st.presc = 2'(st.presc + tccu_pkg::PRESCALE_STEP);
        if (tick)
        begin
            next_st.count = 16'(st.count + tccu_pkg::COUNTER_STEP);
        end

        // Bus answer: ready in the first cycle of the access phase
        next_st.ready  = psel && !penable;
        next_st.slverr = psel && !penable && !mapped;
        if (psel && !penable)
        begin
            next_st.rdata = mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end

        // Register writes (status and read-only bytes ignore them)
        if (acc_wr && mapped)
        begin
            unique case (idx)
                tccu_pkg::IDX_TIMER_CONTROL:
                begin
                    next_st.capture_irq_enable = pwdata[tccu_pkg::CTL_CAPTURE_IRQ_ENABLE];
                    next_st.compare_irq_enable = pwdata[tccu_pkg::CTL_COMPARE_IRQ_ENABLE];
                    next_st.overflow_irq_enable = pwdata[tccu_pkg::CTL_OVERFLOW_IRQ_ENABLE];
                    next_st.edge_sel =
                        pwdata[tccu_pkg::CTL_CAPTURE_EDGE_SELECT];
                    next_st.compare_output_level = pwdata[tccu_pkg::CTL_COMPARE_OUT_LEVEL];
                end
                tccu_pkg::IDX_COMPARE_VALUE_HIGH:
                begin
                    next_st.cmpv[15:8]  = pwdata[7:0];
                    next_st.cmp_inhibit = 1'b1;
                end
                tccu_pkg::IDX_COMPARE_VALUE_LOW:
                begin
                    next_st.cmpv[7:0]   = pwdata[7:0];
                    next_st.cmp_inhibit = 1'b0;
                end
                tccu_pkg::IDX_ANALOG_CONTROL:
                    next_st.src_sel = pwdata[tccu_pkg::ANA_CAPTURE_SOURCE];
                default:
                    next_st.src_sel = st.src_sel;
            endcase
        end

        // Read side effects: arming, capture blocking, flag clearing
        if (acc_rd && mapped)
        begin
            unique case (idx)
                tccu_pkg::IDX_TIMER_FLAGS:
                begin
                    next_st.arm_icf = st.capture_flag;
                    next_st.arm_ocf = st.compare_flag;
                    next_st.arm_tof = st.overflow_flag;
                end
                tccu_pkg::IDX_CAPTURE_VALUE_HIGH:
                    next_st.cap_block = 1'b1;
                tccu_pkg::IDX_CAPTURE_VALUE_LOW:
                begin
                    next_st.cap_block = 1'b0;
                    if (st.arm_icf)
                    begin
                        next_st.capture_flag     = 1'b0;
                        next_st.arm_icf = 1'b0;
                    end
                end
                tccu_pkg::IDX_COUNTER_LOW_BYTE:
                begin
                    if (st.arm_tof)
                    begin
                        next_st.overflow_flag     = 1'b0;
                        next_st.arm_tof = 1'b0;
                    end
                end
                default:
                    next_st.cap_block = st.cap_block;
            endcase
        end

        // Compare low byte access of either direction clears armed flag
        if (acc_done && mapped && st.arm_ocf &&
            (idx == tccu_pkg::IDX_COMPARE_VALUE_LOW))
        begin
            next_st.compare_flag     = 1'b0;
            next_st.arm_ocf = 1'b0;
        end

        // Events set flags; a set wins over a clear in the same cycle
        if (cap_hit)
        begin
            next_st.cap = cap_value;
            next_st.capture_flag = 1'b1;
        end
        if (cmp_hit)
        begin
            next_st.out_latch = st.compare_output_level;
            next_st.compare_flag       = 1'b1;
        end
        if (tick && (st.count == tccu_pkg::COUNTER_ALL_ONE))
        begin
            next_st.overflow_flag = 1'b1;
        end

        // Pin drive and interrupt request
        next_st.oe_n = !compare_pin_is_output;
        next_st.irq  = (st.capture_flag && st.capture_irq_enable) ||
                       (st.compare_flag && st.compare_irq_enable) ||
                       (st.overflow_flag && st.overflow_irq_enable);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Capture, compare value, edge select and flags keep through reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st.presc       <= tccu_pkg::PRESCALE_FIRST;
            st.count       <= tccu_pkg::COUNTER_RESET;
            st.capture_irq_enable        <= 1'b0;
            st.compare_irq_enable        <= 1'b0;
            st.overflow_irq_enable        <= 1'b0;
            st.compare_output_level        <= 1'b0;
            st.src_sel     <= 1'b0;
            st.arm_icf     <= 1'b0;
            st.arm_ocf     <= 1'b0;
            st.arm_tof     <= 1'b0;
            st.cap_block   <= 1'b0;
            st.cmp_inhibit <= 1'b0;
            st.s1          <= 1'b0;
            st.s2          <= 1'b0;
            st.s3          <= 1'b0;
            st.cmp_q       <= 1'b0;
            st.c1          <= 16'h0000;
            st.c2          <= 16'h0000;
            st.out_latch   <= 1'b0;
            st.oe_n        <= 1'b1;
            st.irq         <= 1'b0;
            st.ready       <= 1'b0;
            st.rdata       <= 32'h0000_0000;
            st.slverr      <= 1'b0;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign pready              = st.ready;
    assign prdata              = st.rdata;
    assign pslverr             = st.slverr;
    assign compare_output_pin  = st.out_latch;
    assign compare_output_oe_n = st.oe_n;
    assign timer_irq           = st.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_counter_step: assert property (
        ce && tick |=> st.count == 16'($past(st.count) + 16'h0001))
        else $error("Counter did not advance at prescaler end");
    a_counter_hold: assert property (
        !tick |=> $stable(st.count))
        else $error("Counter moved between prescaler ends");
    a_wrap_flag: assert property (
        ce && tick && st.count == 16'hFFFF |=> st.overflow_flag && st.count == 0)
        else $error("Wrap did not set the overflow flag");
    a_match_level: assert property (
        ce && cmp_hit |=> st.compare_flag && st.out_latch == $past(st.compare_output_level))
        else $error("Match did not latch the output level");
    a_high_inhibit: assert property (
        ce && acc_wr && mapped && idx == tccu_pkg::IDX_COMPARE_VALUE_HIGH
        |=> st.cmp_inhibit && !cmp_hit)
        else $error("Compare high write did not suspend matching");
    a_capture_block: assert property (
        st.cap_block |=> $stable(st.cap))
        else $error("Capture taken while blocked");
    a_flag_capture: assert property (
        ce && cap_hit && st.src_sel
        |=> st.capture_flag && st.cap == 16'($past(st.count) + 16'h0001))
        else $error("Comparator capture value wrong");
    a_low_clears: assert property (
        ce && acc_rd && idx == tccu_pkg::IDX_CAPTURE_VALUE_LOW &&
        st.arm_icf && !cap_hit |=> !st.capture_flag)
        else $error("Capture low read did not clear the flag");
    a_ocf_clear: assert property (
        ce && acc_done && idx == tccu_pkg::IDX_COMPARE_VALUE_LOW &&
        st.arm_ocf && !cmp_hit |=> !st.compare_flag)
        else $error("Compare low access did not clear the flag");
    a_irq_gate: assert property (
        ce && st.overflow_flag && st.overflow_irq_enable |=> st.irq || !ce)
        else $error("Enabled overflow flag gave no request");
    a_ready_next: assert property (
        ce && psel && !penable |=> pready)
        else $error("Slave did not answer in first access cycle");

    c_capture:  cover property (ce && cap_hit);
    c_match:    cover property (ce && cmp_hit);
    c_wrap:     cover property (ce && tick && st.count == 16'hFFFF);
    c_icf_done: cover property (st.capture_flag ##[1:50] !st.capture_flag);

endmodule

// File: timer_capture_compare_unit_test.sv
// Self-checking bench of the timer capture/compare unit over APB.
// Assumes tccu_pkg, tccu_top and tccu_event_source are compiled first.
`timescale 1ns/10ps

module timer_capture_compare_unit_test;
    // ****************************************************************
    // Signals and table
    // ****************************************************************
    typedef struct packed
    {
        logic       w;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] q;
        logic       e;
    } tccu_row_s;

    logic        pclk;
    logic        presetn;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        capture_input_pin;
    logic        comparator_two_flag;
    logic        compare_pin_is_output;
    logic        compare_output_pin;
    logic        compare_output_oe_n;
    logic        timer_irq;
    logic        want_pin;
    logic        want_cmp;
    int          errors;
    int          checks;
    tccu_row_s   rows [12];

    localparam logic [7:0] ad_ctl = {tccu_pkg::IDX_TIMER_CONTROL, 2'h0};
    localparam logic [7:0] ad_flg = {tccu_pkg::IDX_TIMER_FLAGS, 2'h0};
    localparam logic [7:0] ad_cph = {tccu_pkg::IDX_CAPTURE_VALUE_HIGH, 2'h0};
    localparam logic [7:0] ad_cpl = {tccu_pkg::IDX_CAPTURE_VALUE_LOW, 2'h0};
    localparam logic [7:0] ad_cmh = {tccu_pkg::IDX_COMPARE_VALUE_HIGH, 2'h0};
    localparam logic [7:0] ad_cml = {tccu_pkg::IDX_COMPARE_VALUE_LOW, 2'h0};
    localparam logic [7:0] ad_cnh = {tccu_pkg::IDX_COUNTER_HIGH_BYTE, 2'h0};
    localparam logic [7:0] ad_cnl = {tccu_pkg::IDX_COUNTER_LOW_BYTE, 2'h0};
    localparam logic [7:0] ad_ana = {tccu_pkg::IDX_ANALOG_CONTROL, 2'h0};

    // Unit and far side
    tccu_top u_tccu_top (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .capture_input_pin,
        .comparator_two_flag, .compare_pin_is_output, .compare_output_pin,
        .compare_output_oe_n, .timer_irq);
    tccu_event_source u_tccu_event_source (.pclk, .want_pin, .want_cmp,
        .capture_input_pin, .comparator_two_flag);

    // 20 MHz clock
    initial
    begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, x);
        checks++;
        if (s !== x)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, x, s);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled
    task automatic bus(input logic w, input logic [7:0] a, d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1)
        begin
            errors++;
            close_out();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, d);
        logic [31:0] q;
        logic        e;
        bus(1'h1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        bus(1'h0, a, 8'h00, q, e);
    endtask

    // Reset pulse; outputs are looked at while it is held
    task automatic do_reset();
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        chk("oe_n", compare_output_oe_n, 1);
        chk("cmp_pin", compare_output_pin, 0);
        presetn <= 1'h1;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [31:0] q;
        logic [31:0] c;
        logic [31:0] cap;
        logic [7:0]  dl;
        logic        e;
        int          n;
        {presetn, ce, psel, penable, pwrite, paddr, pwdata} = '0;
        {compare_pin_is_output, want_pin, want_cmp} = '0;
        ce = 1'h1;
        errors = 0;
        checks = 0;
        rows[0]  = '{1'h1, ad_ctl, 8'hE3, 8'h00, 1'h0};
        rows[1]  = '{1'h0, ad_ctl, 8'h00, 8'hE3, 1'h0};
        rows[2]  = '{1'h1, ad_cmh, 8'h12, 8'h00, 1'h0};
        rows[3]  = '{1'h1, ad_cml, 8'h34, 8'h00, 1'h0};
        rows[4]  = '{1'h0, ad_cmh, 8'h00, 8'h12, 1'h0};
        rows[5]  = '{1'h0, ad_cml, 8'h00, 8'h34, 1'h0};
        rows[6]  = '{1'h1, ad_ana, 8'h01, 8'h00, 1'h0};
        rows[7]  = '{1'h0, ad_ana, 8'h00, 8'h01, 1'h0};
        rows[8]  = '{1'h1, ad_ana, 8'h00, 8'h00, 1'h0};
        rows[9]  = '{1'h0, ad_ana, 8'h00, 8'h00, 1'h0};
        rows[10] = '{1'h0, 8'h00, 8'h00, 8'h00, 1'h1};
        rows[11] = '{1'h0, 8'h49, 8'h00, 8'h00, 1'h1};
        do_reset();
        rd(ad_cnh, q);
        chk("cnt_hi", q, 32'h0000_00FF);
        for (int i = 0; i < 12; i++)
        begin
            bus(rows[i].w, rows[i].a, rows[i].d, q, e);
            chk("slverr", e, rows[i].e);
            if (rows[i].w === 1'h0)
                chk("rdata", q, {24'h00_0000, rows[i].q});
        end
        // Mid-run reset keeps edge select and compare value
        do_reset();
        rd(ad_ctl, q);
        chk("ctl_rst", q, 32'h0000_0002);
        rd(ad_cmh, q);
        chk("cmp_hi", q, 32'h0000_0012);
        // Compare match drives level one onto the pin
        wr(ad_ctl, 8'h43);
        compare_pin_is_output <= 1'h1;
        wr(ad_cmh, 8'h00);
        rd(ad_flg, q);
        wr(ad_cml, 8'h30);
        for (n = 0; n < 400 && compare_output_pin !== 1'h1; n++)
            @(posedge pclk);
        chk("cmp_pin", compare_output_pin, 1);
        rd(ad_flg, q);
        chk("cmp_flag", q[6], 1);
        chk("ovf_flag", q[5], 1);
        chk("irq", timer_irq, 1);
        chk("oe_n", compare_output_oe_n, 0);
        wr(ad_cml, 8'h30);
        rd(ad_cnl, q);
        rd(ad_flg, q);
        chk("cmp_clr", q[6], 0);
        chk("ovf_clr", q[5], 0);
        chk("irq_off", timer_irq, 0);
        // Clock enable low freezes the counter
        rd(ad_cnl, c);
        ce <= 1'h0;
        repeat (40) @(posedge pclk);
        ce <= 1'h1;
        rd(ad_cnl, q);
        dl = q[7:0] - c[7:0];
        chk("ce_hold", dl <= 8'h01, 1);
        // Rising pin edge captures the counter plus one
        wr(ad_ctl, 8'h02);
        rd(ad_cnl, c);
        want_pin <= 1'h1;
        repeat (8) @(posedge pclk);
        rd(ad_cpl, cap);
        dl = cap[7:0] - c[7:0];
        chk("cap_step", dl == 8'h01 || dl == 8'h02, 1);
        rd(ad_flg, q);
        chk("cap_flag", q[7], 1);
        rd(ad_cpl, q);
        rd(ad_flg, q);
        chk("cap_clr", q[7], 0);
        // Writes to the status register change nothing
        wr(ad_flg, 8'hE0);
        rd(ad_flg, q);
        chk("flg_wr", q, 32'h0000_0000);
        // High byte read blocks the next capture
        rd(ad_cph, q);
        want_pin <= 1'h0;
        repeat (8) @(posedge pclk);
        want_pin <= 1'h1;
        repeat (8) @(posedge pclk);
        rd(ad_flg, q);
        chk("blk_flag", q[7], 0);
        rd(ad_cpl, q);
        chk("blk_val", q, cap);
        // Comparator two flag as source; software sets the source select bit
        wr(ad_ana, 8'h01);
        want_cmp <= 1'h1;
        repeat (8) @(posedge pclk);
        rd(ad_flg, q);
        chk("cmp_src", q[7], 1);
        rd(ad_cpl, q);
        // Falling pin edge with edge select zero
        wr(ad_ana, 8'h00);
        wr(ad_ctl, 8'h00);
        want_pin <= 1'h0;
        repeat (8) @(posedge pclk);
        rd(ad_flg, q);
        chk("fall_cap", q[7], 1);
        // Reset keeps the capture value
        rd(ad_cpl, cap);
        do_reset();
        rd(ad_cpl, q);
        chk("cap_keep", q, cap);
        close_out();
    end
endmodule
